// [design/swd_tick_div.v]
// divider that makes one-cycle second and minute enable pulses
`timescale 1ns/1ns
`default_nettype none
`include "sio_wdt_regs.vh"

module swd_tick_div #(
	parameter SECOND_CYCLES = `SWD_SECOND_CYCLES,
	parameter MINUTE_TICKS  = `SWD_MINUTE_TICKS
) (
	// clock and reset
	input  wire        clk,
	input  wire        nrst,
	// restart the time base
	input  wire        restart,
	// one-cycle enables
	output reg         sec_tick_r,
	output reg         min_tick_r
);
	reg  [31:0] cyc_r;
	reg  [7:0]  sec_cnt_r;

	// ************************************************************
	// cascade of cycle and second counters
	// ************************************************************
	// restart keeps the first unit whole after a reload
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cyc_r      <= 32'h00000000;
			sec_cnt_r  <= 8'h00;
			sec_tick_r <= 1'b0;
			min_tick_r <= 1'b0;
		end else if (restart) begin
			cyc_r      <= 32'h00000000;
			sec_cnt_r  <= 8'h00;
			sec_tick_r <= 1'b0;
			min_tick_r <= 1'b0;
		end else begin
			sec_tick_r <= 1'b0;
			min_tick_r <= 1'b0;
			if (cyc_r == SECOND_CYCLES - 1) begin
				cyc_r      <= 32'h00000000;
				sec_tick_r <= 1'b1;
				if (sec_cnt_r == MINUTE_TICKS - 1) begin
					sec_cnt_r  <= 8'h00;
					min_tick_r <= 1'b1;
				end else begin
					sec_cnt_r <= sec_cnt_r + 8'h01;
				end
			end else begin
				cyc_r <= cyc_r + 32'h00000001;
			end
		end
	end
endmodule
`default_nettype wire

// [design/swd_watchdog.v]
// super i/o watchdog: index/data configuration ports and countdown
//
// What this block does
// - counter counts down from the preset and fires system reset on reaching zero
// - two unlock bytes in a row on the index port open configuration mode
// - time unit register: zero selects seconds, eight selects minutes
// - count register holds the timeout in units; writing it loads the countdown
//
// the host port bus runs on clk, so its strobes pass no synchroniser
// count zero parks the timer: it never fires until a nonzero count is written
// a count write or an activation write restarts the time base, so the
// first unit after any reload is always a whole unit
// a time unit change takes effect at the next tick of the new unit
// the reset pulse width is set by RST_PULSE_CYC; software can stretch it only by a reload that expires again during the pulse
// a fresh expiry during a running pulse restarts the full pulse width
`timescale 1ns/1ns
`default_nettype none
`include "sio_wdt_regs.vh"

module swd_watchdog #(
	parameter SECOND_CYCLES = `SWD_SECOND_CYCLES,
	parameter MINUTE_TICKS  = `SWD_MINUTE_TICKS,
	parameter RST_PULSE_CYC = `SWD_RST_PULSE_CYC
) (
	// clock and reset
	input  wire        clk,
	input  wire        nrst,
	// i/o port bus, single-cycle strobes
	input  wire [15:0] io_addr,
	input  wire        io_wr,
	input  wire        io_rd,
	input  wire [7:0]  io_wdata,
	output reg  [7:0]  io_rdata_r,
	output reg         io_rvalid_r,
	// system reset request and state
	output reg         sys_reset_r,
	output wire        wdog_running
);
	// unlock sequence states
	localparam ST_LOCKED = 2'h0;
	localparam ST_HALF   = 2'h1;
	localparam ST_OPEN   = 2'h2;

	reg  [1:0] cfg_st_r;
	reg  [1:0] cfg_st_nxt;
	reg  [7:0] index_r;
	reg  [7:0] ldn_r;
	reg  [7:0] activate_r;
	reg  [7:0] unit_r;
	reg  [7:0] count_r;
	reg  [7:0] remain_r;
	reg  [7:0] pulse_r;
	reg        fired_r;
	// read selection ahead of the read data register
	reg  [7:0] rd_mux;

	wire wr_index = io_wr && (io_addr == `SWD_INDEX_PORT);
	wire wr_data  = io_wr && (io_addr == `SWD_DATA_PORT);
	wire rd_data  = io_rd && (io_addr == `SWD_DATA_PORT);
	wire cfg_open = (cfg_st_r == ST_OPEN);
	wire wd_sel   = (ldn_r == `SWD_LDN_WATCHDOG);
	wire wr_act   = cfg_open && wr_data && wd_sel && (index_r == `SWD_REG_ACTIVATE);
	wire wr_unit  = cfg_open && wr_data && wd_sel && (index_r == `SWD_REG_TIME_UNIT);
	wire wr_count = cfg_open && wr_data && wd_sel && (index_r == `SWD_REG_COUNT);
	wire enabled  = activate_r[`SWD_ACT_BIT];
	wire sec_tick;
	wire min_tick;
	wire unit_tick;
	wire reload;
	// countdown qualifiers
	wire count_step;
	wire expire;

	assign unit_tick    = (unit_r == `SWD_UNIT_MINUTES) ? min_tick : sec_tick;
	assign reload       = wr_count || wr_act;
	assign wdog_running = enabled && (remain_r != `SWD_RESET_ZERO) && !fired_r;

	// ************************************************************
	// time base
	// ************************************************************
	swd_tick_div #(
		.SECOND_CYCLES (SECOND_CYCLES),
		.MINUTE_TICKS  (MINUTE_TICKS)
	) u_div (
		.clk        (clk),
		.nrst       (nrst),
		.restart    (reload),
		.sec_tick_r (sec_tick),
		.min_tick_r (min_tick)
	);

	// ************************************************************
	// unlock sequence
	// ************************************************************
	// any other index write between the two unlock bytes starts over
	always @* begin
		cfg_st_nxt = cfg_st_r;
		case (cfg_st_r)
			ST_LOCKED: begin
				if (wr_index && io_wdata == `SWD_UNLOCK_BYTE)
					cfg_st_nxt = ST_HALF;
			end
			ST_HALF: begin
				if (wr_index)
					cfg_st_nxt = (io_wdata == `SWD_UNLOCK_BYTE) ? ST_OPEN : ST_LOCKED;
			end
			ST_OPEN: begin
				if (wr_index && io_wdata == `SWD_LOCK_BYTE)
					cfg_st_nxt = ST_LOCKED;
			end
			default: cfg_st_nxt = ST_LOCKED;
		endcase
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst)
			cfg_st_r <= ST_LOCKED;
		else
			cfg_st_r <= cfg_st_nxt;
	end

	// ************************************************************
	// configuration registers
	// ************************************************************
	// accesses are ignored until the unlock completes
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			index_r    <= `SWD_RESET_ZERO;
			ldn_r      <= `SWD_RESET_ZERO;
			activate_r <= `SWD_RESET_ZERO;
			unit_r     <= `SWD_UNIT_SECONDS;
			count_r    <= `SWD_RESET_ZERO;
		end else begin
			if (cfg_open && wr_index)
				index_r <= io_wdata;
			if (cfg_open && wr_data && index_r == `SWD_LDN_INDEX)
				ldn_r <= io_wdata;
			if (wr_act)
				activate_r <= io_wdata;
			if (wr_unit)
				unit_r <= io_wdata;
			if (wr_count)
				count_r <= io_wdata;
		end
	end

	// ************************************************************
	// read path
	// ************************************************************
	// locked, foreign-device or unmapped reads give zero
	always @* begin
		rd_mux = 8'h00;
		if (cfg_open) begin
			if (index_r == `SWD_LDN_INDEX)
				rd_mux = ldn_r;
			else if (wd_sel && index_r == `SWD_REG_ACTIVATE)
				rd_mux = activate_r;
			else if (wd_sel && index_r == `SWD_REG_TIME_UNIT)
				rd_mux = unit_r;
			else if (wd_sel && index_r == `SWD_REG_COUNT)
				rd_mux = remain_r; // live count shows progress
		end
	end

	// read data registered one cycle after the strobe, zero between reads
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			io_rdata_r  <= 8'h00;
			io_rvalid_r <= 1'b0;
		end else begin
			io_rvalid_r <= rd_data;
			if (rd_data)
				io_rdata_r <= rd_mux;
			else
				io_rdata_r <= 8'h00;
		end
	end

	// ************************************************************
	// countdown and reset pulse
	// ************************************************************
	// a unit tick only counts while enabled, armed and not yet expired;
	// a reload in the same cycle wins, so software that is just in time is spared
	assign count_step = enabled && !fired_r && (remain_r != `SWD_RESET_ZERO) && unit_tick;
	assign expire     = count_step && (remain_r == 8'h01) && !reload;

	// a count write restarts the countdown, even after expiry
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			remain_r <= `SWD_RESET_ZERO;
			fired_r  <= 1'b0;
		end else if (wr_count) begin
			remain_r <= io_wdata;
			fired_r  <= 1'b0;
		end else if (wr_act) begin
			remain_r <= count_r;
			fired_r  <= 1'b0;
		end else if (count_step) begin
			remain_r <= remain_r - 8'h01;
			if (expire)
				fired_r <= 1'b1;
		end
	end

	// reset pulse; an expiry outranks the running pulse countdown
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pulse_r     <= 8'h00;
			sys_reset_r <= 1'b0;
		end else if (expire) begin
			pulse_r     <= RST_PULSE_CYC[7:0];
			sys_reset_r <= 1'b1;
		end else if (sys_reset_r) begin
			pulse_r <= pulse_r - 8'h01;
			if (pulse_r == 8'h01)
				sys_reset_r <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [inc/sio_wdt_regs.vh]
// register map, codes and timing constants of the super i/o watchdog
`ifndef SIO_WDT_REGS_VH
`define SIO_WDT_REGS_VH

// ************************************************************
// port addresses and unlock code
// ************************************************************
`define SWD_INDEX_PORT   16'h002E
`define SWD_DATA_PORT    16'h002F
`define SWD_UNLOCK_BYTE  8'h87
`define SWD_LOCK_BYTE    8'hAA
`define SWD_LDN_INDEX    8'h07
`define SWD_LDN_WATCHDOG 8'h08

// ************************************************************
// register indices and values
// ************************************************************
`define SWD_REG_ACTIVATE  8'h30
`define SWD_REG_TIME_UNIT 8'hF0
`define SWD_REG_COUNT     8'hF1
`define SWD_UNIT_SECONDS  8'h00
`define SWD_UNIT_MINUTES  8'h08
`define SWD_ACT_BIT       0
`define SWD_RESET_ZERO    8'h00

// ************************************************************
// timing
// ************************************************************
`define SWD_CLK_HZ        50000000
`define SWD_SECOND_CYCLES (`SWD_CLK_HZ * 1)
`define SWD_MINUTE_TICKS  60
`define SWD_RST_PULSE_CYC 16

`endif

// [testbench/swd_watchdog_bench.sv]
// self-checking bench of the watchdog
`timescale 1ns/1ns
`default_nettype none
module swd_watchdog_bench;
	logic        clk = 0;
	logic        nrst = 0;
	logic [15:0] io_addr = 16'h0000;
	logic        io_wr = 0;
	logic        io_rd = 0;
	logic [7:0]  io_wdata = 8'h00;
	wire  [7:0]  io_rdata_r;
	wire         io_rvalid_r;
	wire         sys_reset_r;
	wire         wdog_running;
	int          err_count = 0;
	int          cmp_count = 0;
	logic [7:0]  rd_q;
	logic        rv_q;
	// short units keep the run brief
	swd_watchdog #(.SECOND_CYCLES(10), .MINUTE_TICKS(3), .RST_PULSE_CYC(16)) DUT (.clk(clk), .nrst(nrst),
		.io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_r(io_rdata_r),
		.io_rvalid_r(io_rvalid_r), .sys_reset_r(sys_reset_r), .wdog_running(wdog_running));
	initial forever #10 clk = ~clk;
	// ****
	// tasks
	// ****
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one strobe cycle; strobes drop a cycle later, so calls never collide
	task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		io_wr = w;
		io_rd = !w;
		io_addr = a;
		io_wdata = d;
		@(negedge clk);
		io_wr = 0;
		io_rd = 0;
		rd_q = io_rdata_r;
		rv_q = io_rvalid_r;
	endtask
	task automatic cfg(input logic [7:0] i, input logic [7:0] d);
		io(1, 16'h002E, i);
		io(1, 16'h002F, d);
	endtask
	task automatic rdc(input string nm, input logic [7:0] i, input logic [7:0] e);
		io(1, 16'h002E, i);
		io(0, 16'h002F, 8'h00);
		chk(nm, e, rd_q);
		chk("read valid", 8'h01, {7'h00, rv_q});
	endtask
	// fire time in cycles after the last write, then pulse length
	task automatic fire(input int lo, input int hi);
		int n;
		int w;
		n = 0;
		w = 0;
		while (sys_reset_r !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		chk("fire time", 8'h01, 8'(n >= lo && n <= hi));
		while (sys_reset_r === 1'b1 && w < 40) begin
			@(negedge clk);
			w++;
		end
		chk("pulse width", 8'h10, 8'(w));
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_lock;
		cfg(8'h07, 8'h08);
		io(1, 16'h002E, 8'h87);
		io(1, 16'h002E, 8'h07);
		io(1, 16'h002E, 8'h87);
		rdc("locked read", 8'hF1, 8'h00);
		io(1, 16'h002E, 8'h87);
		io(1, 16'h002E, 8'h87);
		rdc("ldn ignored", 8'h07, 8'h00);
		$display("lock test done");
	endtask
	task automatic t_regs;
		cfg(8'h07, 8'h05);
		cfg(8'hF0, 8'h08);
		rdc("other device", 8'hF0, 8'h00);
		cfg(8'h07, 8'h08);
		rdc("unit kept", 8'hF0, 8'h00);
		cfg(8'hF0, 8'h08);
		rdc("unit minutes", 8'hF0, 8'h08);
		cfg(8'hF1, 8'h0A);
		rdc("count", 8'hF1, 8'h0A);
		rdc("activate off", 8'h30, 8'h00);
		$display("register test done");
	endtask
	task automatic t_units;
		cfg(8'hF0, 8'h00);
		cfg(8'hF1, 8'h03);
		cfg(8'h30, 8'h01);
		chk("running", 8'h01, 8'(wdog_running));
		fire(27, 33);
		cfg(8'hF0, 8'h08);
		cfg(8'hF1, 8'h02);
		cfg(8'h30, 8'h01);
		fire(57, 63);
		$display("unit test done");
	endtask
	task automatic t_reload;
		cfg(8'hF0, 8'h00);
		cfg(8'hF1, 8'h03);
		cfg(8'h30, 8'h01);
		repeat (20) @(negedge clk);
		cfg(8'hF1, 8'h03);
		fire(27, 33);
		cfg(8'hF1, 8'h03);
		cfg(8'h30, 8'h00);
		// a live count would be inside its reset pulse here
		repeat (40) @(negedge clk);
		chk("disabled", 8'h00, {7'h00, sys_reset_r | wdog_running});
		rdc("held count", 8'hF1, 8'h03);
		io(1, 16'h002E, 8'hAA);
		rdc("relocked", 8'hF1, 8'h00);
		$display("reload test done");
	endtask
	initial begin
		repeat (8) @(negedge clk);
		nrst = 1;
		t_lock();
		t_regs();
		t_units();
		t_reload();
		conclude();
	end
	// hang guard
	initial begin
		#2000000;
		err_count++;
		conclude();
	end
endmodule
bind swd_watchdog swd_watchdog_props u_props (.clk(clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr),
	.io_rd(io_rd), .io_rvalid_r(io_rvalid_r), .sys_reset_r(sys_reset_r), .wdog_running(wdog_running));
`default_nettype wire

// [testbench/swd_watchdog_props.sv]
// port assertions for the watchdog
`timescale 1ns/1ns
`default_nettype none
module swd_watchdog_props (
	// watched ports
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [15:0] io_addr,
	input wire logic        io_wr,
	input wire logic        io_rd,
	input wire logic        io_rvalid_r,
	input wire logic        sys_reset_r,
	input wire logic        wdog_running
);
	// ****
	// rules
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// data port write, the only way to start the count or stop it before expiry
	wire dwr = io_wr && io_addr == 16'h002F;
	a_read_answer: assert property (io_rd && io_addr == 16'h002F |=> io_rvalid_r)
		else $error("read got no answer");
	a_pulse_width: assert property ($rose(sys_reset_r) |-> sys_reset_r[*8] ##1 sys_reset_r[*8] ##1 !sys_reset_r)
		else $error("reset pulse width wrong");
	a_fire_ends_run: assert property ($rose(sys_reset_r) |-> $past(wdog_running) && !wdog_running)
		else $error("reset without a running count");
	a_start_by_write: assert property ($rose(wdog_running) |-> $past(dwr))
		else $error("count started without a write");
	a_no_early_fire: assert property ($rose(wdog_running) |=> !sys_reset_r[*8])
		else $error("reset fired before one unit");
	a_stop_cause: assert property ($fell(wdog_running) |-> sys_reset_r || $past(dwr))
		else $error("count stopped without cause");
	c_fire: cover property ($rose(sys_reset_r));
	c_run: cover property ($rose(wdog_running));
	c_read: cover property (io_rvalid_r);
endmodule
`default_nettype wire
